// *** core/iop_pkg.sv ***
// constants for the i/o port pin configuration and change notification block
package iop_pkg;
   localparam int          PIN_COUNT        = 16;
   localparam int          CHANGE_COUNT     = 24;
   localparam int          ADDR_W           = 4;
   // register offsets (word index on the plain register port)
   localparam logic [3:0]  OFS_LATCH        = 4'h0;
   localparam logic [3:0]  OFS_DIRECTION    = 4'h1;
   localparam logic [3:0]  OFS_PORT         = 4'h2;
   localparam logic [3:0]  OFS_OPEN_DRAIN   = 4'h3;
   localparam logic [3:0]  OFS_SEL_FIRST    = 4'h4;
   localparam logic [3:0]  OFS_SEL_SECOND   = 4'h5;
   localparam logic [3:0]  OFS_CHG_EN_LOW   = 4'h6;
   localparam logic [3:0]  OFS_CHG_EN_HIGH  = 4'h7;
   localparam logic [3:0]  OFS_PU_EN_LOW    = 4'h8;
   localparam logic [3:0]  OFS_PU_EN_HIGH   = 4'h9;
   localparam logic [3:0]  OFS_IRQ_STATUS   = 4'ha;
   localparam logic [3:0]  OFS_IRQ_MASK     = 4'hb;
   // reset values
   localparam logic [15:0] RST_LATCH        = 16'h0000;
   localparam logic [15:0] RST_DIRECTION    = 16'hffff;
   localparam logic [15:0] RST_OPEN_DRAIN   = 16'h0000;
   localparam logic [15:0] RST_ANALOG_SEL   = 16'h0000;
   localparam logic [15:0] RST_CHG_EN       = 16'h0000;
   localparam logic [15:0] RST_PU_EN        = 16'h0000;
   localparam logic [0:0]  RST_IRQ_MASK     = 1'h0;
   // field split of the 24 change inputs over two 16-bit registers
   localparam int          CHG_LOW_W        = 16;
   localparam int          CHG_HIGH_W       = 8;
endpackage : iop_pkg

// *** core/iop_port.sv ***
// i/o port pin logic with analog select, open-drain and change notification
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - set open-drain bit gives open-drain drive
// - analog output pin converts its driven level
// - cleared select bit means analog pin
// - select bits reset to zero, analog
// - analog if either converter bit cleared
// - analog pins read zero from port
// - digital pins never feed the converter
// - enabled pin change raises interrupt, sleep too
// - twenty-four monitored change inputs
// - per-pin change enable over two registers
// - per-pin pull-up enable over two registers
// - digital mode enables read, mux grounded
module iop_port #(
   parameter int PINS    = iop_pkg::PIN_COUNT,
   parameter int CHANGES = iop_pkg::CHANGE_COUNT
) (
   input  wire logic                       CLOCK_I,
   input  wire logic                       RESET_I,
   input  wire logic [iop_pkg::ADDR_W-1:0] REG_ADDR_I,
   input  wire logic [15:0]                REG_WDATA_I,
   input  wire logic                       REG_WRITE_I,
   input  wire logic                       REG_READ_I,
   output      logic [15:0]                REG_RDATA_O,
   input  wire logic [PINS-1:0]            PIN_I,
   output      logic [PINS-1:0]            PIN_O,
   output      logic [PINS-1:0]            PIN_OE_N_O,
   input  wire logic [CHANGES-1:0]         CHANGE_PIN_I,
   output      logic [CHANGES-1:0]         PULLUP_EN_O,
   input  wire logic                       SLEEP_I,
   output      logic [PINS-1:0]            CONVERTER_SAMPLE_EN_O,
   output      logic [PINS-1:0]            CONVERTER_LEVEL_O,
   output      logic [PINS-1:0]            CONVERTER_GROUND_O,
   output      logic                       IRQ_O
);

   //////////////////////////////////////////////////////////////////////////////
   // register state
   logic [PINS-1:0]    output_latch_r, output_latch_nxt;
   logic [PINS-1:0]    direction_control_r, direction_control_nxt;
   logic [PINS-1:0]    open_drain_select_r, open_drain_select_nxt;
   logic [PINS-1:0]    first_converter_pin_select_r, first_converter_pin_select_nxt;
   logic [PINS-1:0]    second_converter_pin_select_r, second_converter_pin_select_nxt;
   logic [15:0]        change_enable_low_reg_r, change_enable_low_reg_nxt;
   logic [15:0]        change_enable_high_reg_r, change_enable_high_reg_nxt;
   logic [15:0]        pullup_enable_low_reg_r, pullup_enable_low_reg_nxt;
   logic [15:0]        pullup_enable_high_reg_r, pullup_enable_high_reg_nxt;
   logic               irq_status_r, irq_status_nxt;
   logic               irq_mask_r, irq_mask_nxt;
   logic [15:0]        rdata_r, rdata_nxt;
   logic [PINS-1:0]    pin_meta_r, pin_sync_r;
   logic [CHANGES-1:0] chg_meta_r, chg_sync_r, chg_last_r;
   logic               sleep_event_r;
   logic [PINS-1:0]    pin_meta_nxt, pin_sync_nxt;
   logic [CHANGES-1:0] chg_meta_nxt, chg_sync_nxt, chg_last_nxt;
   logic               sleep_event_nxt;
   logic [CHANGES-1:0] change_enable_bit;
   logic [CHANGES-1:0] pullup_enable_bit;
   logic [PINS-1:0]    analog_pin_bit;
   logic [PINS-1:0]    port_value;
   logic               change_seen;
   logic               wake_change;
   logic               wr_latch;
   logic               wr_direction;
   logic               wr_open_drain;
   logic               wr_sel_first;
   logic               wr_sel_second;
   logic               wr_chg_low;
   logic               wr_chg_high;
   logic               wr_pu_low;
   logic               wr_pu_high;
   logic               wr_mask;
   logic               rd_status;

   // decode used by both the write and the read paths
   function automatic logic hit(input logic [iop_pkg::ADDR_W-1:0] a,
                                input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   //////////////////////////////////////////////////////////////////////////////
   // pin configuration
   // a pin is analog when either converter clears its bit; digital needs both set
   assign analog_pin_bit = ~(first_converter_pin_select_r & second_converter_pin_select_r);

   // analog pins have port read disabled, so they read as zero
   assign port_value = pin_sync_r & ~analog_pin_bit;

   genvar g;
   generate
      for (g = 0; g < PINS; g++) begin : g_pin
         always_comb begin
            // open-drain only drives low; a high releases the pin
            if (open_drain_select_r[g]) begin
               PIN_O[g]      = 1'b0;
               PIN_OE_N_O[g] = direction_control_r[g] | output_latch_r[g];
            end else begin
               PIN_O[g]      = output_latch_r[g];
               PIN_OE_N_O[g] = direction_control_r[g];
            end
         end
         // converter sees the pin only when analog, else the mux is grounded
         assign CONVERTER_SAMPLE_EN_O[g] = analog_pin_bit[g];
         assign CONVERTER_GROUND_O[g]    = ~analog_pin_bit[g];
         // an analog pin left as output converts its own driven level
         assign CONVERTER_LEVEL_O[g] = direction_control_r[g] ? 1'b0
                                                                : output_latch_r[g];
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////////
   // change notification
   assign change_enable_bit = {change_enable_high_reg_r[iop_pkg::CHG_HIGH_W-1:0],
                               change_enable_low_reg_r};
   assign pullup_enable_bit = {pullup_enable_high_reg_r[iop_pkg::CHG_HIGH_W-1:0],
                               pullup_enable_low_reg_r};
   assign PULLUP_EN_O       = pullup_enable_bit;

   assign change_seen = |((chg_sync_r ^ chg_last_r) & change_enable_bit);

   // in sleep the system clock may stop; this combinational term keeps a wake
   // request alive on the raw pins against the captured levels
   assign wake_change = SLEEP_I & |((CHANGE_PIN_I ^ chg_last_r) & change_enable_bit);

   always_comb begin
      pin_meta_nxt    = PIN_I;
      pin_sync_nxt    = pin_meta_r;
      chg_meta_nxt    = CHANGE_PIN_I;
      chg_sync_nxt    = chg_meta_r;
      chg_last_nxt    = chg_sync_r;
      sleep_event_nxt = wake_change;
   end

   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         pin_meta_r    <= '0;
         pin_sync_r    <= '0;
         chg_meta_r    <= '0;
         chg_sync_r    <= '0;
         chg_last_r    <= '0;
         sleep_event_r <= 1'b0;
      end else begin
         pin_meta_r    <= pin_meta_nxt;
         pin_sync_r    <= pin_sync_nxt;
         chg_meta_r    <= chg_meta_nxt;
         chg_sync_r    <= chg_sync_nxt;
         chg_last_r    <= chg_last_nxt;
         sleep_event_r <= sleep_event_nxt;
      end
   end

   // interrupt line follows the sticky flag, or the raw wake term in sleep
   assign IRQ_O = (irq_status_r | wake_change) & irq_mask_r;

   //////////////////////////////////////////////////////////////////////////////
   // register port: one strobe per register, with port writes sharing the latch strobe; shared by the groups below
   assign wr_latch      = REG_WRITE_I & (hit(REG_ADDR_I, iop_pkg::OFS_LATCH)
                                         | hit(REG_ADDR_I, iop_pkg::OFS_PORT));
   assign wr_direction  = REG_WRITE_I & hit(REG_ADDR_I, iop_pkg::OFS_DIRECTION);
   assign wr_open_drain = REG_WRITE_I & hit(REG_ADDR_I, iop_pkg::OFS_OPEN_DRAIN);
   assign wr_sel_first  = REG_WRITE_I & hit(REG_ADDR_I, iop_pkg::OFS_SEL_FIRST);
   assign wr_sel_second = REG_WRITE_I & hit(REG_ADDR_I, iop_pkg::OFS_SEL_SECOND);
   assign wr_chg_low    = REG_WRITE_I & hit(REG_ADDR_I, iop_pkg::OFS_CHG_EN_LOW);
   assign wr_chg_high   = REG_WRITE_I & hit(REG_ADDR_I, iop_pkg::OFS_CHG_EN_HIGH);
   assign wr_pu_low     = REG_WRITE_I & hit(REG_ADDR_I, iop_pkg::OFS_PU_EN_LOW);
   assign wr_pu_high    = REG_WRITE_I & hit(REG_ADDR_I, iop_pkg::OFS_PU_EN_HIGH);
   assign wr_mask       = REG_WRITE_I & hit(REG_ADDR_I, iop_pkg::OFS_IRQ_MASK);
   assign rd_status     = REG_READ_I & hit(REG_ADDR_I, iop_pkg::OFS_IRQ_STATUS);

   // pin configuration registers
   always_comb begin
      output_latch_nxt                = output_latch_r;
      direction_control_nxt           = direction_control_r;
      open_drain_select_nxt           = open_drain_select_r;
      first_converter_pin_select_nxt  = first_converter_pin_select_r;
      second_converter_pin_select_nxt = second_converter_pin_select_r;
      if (wr_latch) begin
         output_latch_nxt = REG_WDATA_I[PINS-1:0];
      end
      if (wr_direction) begin
         direction_control_nxt = REG_WDATA_I[PINS-1:0];
      end
      if (wr_open_drain) begin
         open_drain_select_nxt = REG_WDATA_I[PINS-1:0];
      end
      if (wr_sel_first) begin
         first_converter_pin_select_nxt = REG_WDATA_I[PINS-1:0];
      end
      if (wr_sel_second) begin
         second_converter_pin_select_nxt = REG_WDATA_I[PINS-1:0];
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         output_latch_r                <= iop_pkg::RST_LATCH[PINS-1:0];
         direction_control_r           <= iop_pkg::RST_DIRECTION[PINS-1:0];
         open_drain_select_r           <= iop_pkg::RST_OPEN_DRAIN[PINS-1:0];
         first_converter_pin_select_r  <= iop_pkg::RST_ANALOG_SEL[PINS-1:0];
         second_converter_pin_select_r <= iop_pkg::RST_ANALOG_SEL[PINS-1:0];
      end else begin
         output_latch_r                <= output_latch_nxt;
         direction_control_r           <= direction_control_nxt;
         open_drain_select_r           <= open_drain_select_nxt;
         first_converter_pin_select_r  <= first_converter_pin_select_nxt;
         second_converter_pin_select_r <= second_converter_pin_select_nxt;
      end
   end

   // change and pull-up enables; high registers keep only the upper inputs
   always_comb begin
      change_enable_low_reg_nxt  = change_enable_low_reg_r;
      change_enable_high_reg_nxt = change_enable_high_reg_r;
      pullup_enable_low_reg_nxt  = pullup_enable_low_reg_r;
      pullup_enable_high_reg_nxt = pullup_enable_high_reg_r;
      if (wr_chg_low) begin
         change_enable_low_reg_nxt = REG_WDATA_I;
      end
      if (wr_chg_high) begin
         change_enable_high_reg_nxt = {8'h00, REG_WDATA_I[iop_pkg::CHG_HIGH_W-1:0]};
      end
      if (wr_pu_low) begin
         pullup_enable_low_reg_nxt = REG_WDATA_I;
      end
      if (wr_pu_high) begin
         pullup_enable_high_reg_nxt = {8'h00, REG_WDATA_I[iop_pkg::CHG_HIGH_W-1:0]};
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         change_enable_low_reg_r  <= iop_pkg::RST_CHG_EN;
         change_enable_high_reg_r <= iop_pkg::RST_CHG_EN;
         pullup_enable_low_reg_r  <= iop_pkg::RST_PU_EN;
         pullup_enable_high_reg_r <= iop_pkg::RST_PU_EN;
      end else begin
         change_enable_low_reg_r  <= change_enable_low_reg_nxt;
         change_enable_high_reg_r <= change_enable_high_reg_nxt;
         pullup_enable_low_reg_r  <= pullup_enable_low_reg_nxt;
         pullup_enable_high_reg_r <= pullup_enable_high_reg_nxt;
      end
   end

   // a change in the clearing cycle still sets the flag, so no event is lost
   always_comb begin
      irq_mask_nxt   = irq_mask_r;
      irq_status_nxt = irq_status_r;
      if (wr_mask) begin
         irq_mask_nxt = REG_WDATA_I[0];
      end
      if (rd_status) begin
         irq_status_nxt = 1'b0;
      end
      if (change_seen || sleep_event_r) begin
         irq_status_nxt = 1'b1;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         irq_status_r <= 1'b0;
         irq_mask_r   <= iop_pkg::RST_IRQ_MASK;
      end else begin
         irq_status_r <= irq_status_nxt;
         irq_mask_r   <= irq_mask_nxt;
      end
   end

   // read mux; data stands for one cycle, zero otherwise
   always_comb begin
      rdata_nxt = 16'h0000;
      if (REG_READ_I) begin
         case (REG_ADDR_I)
            iop_pkg::OFS_LATCH:       rdata_nxt = 16'(output_latch_r);
            iop_pkg::OFS_DIRECTION:   rdata_nxt = 16'(direction_control_r);
            iop_pkg::OFS_PORT:        rdata_nxt = 16'(port_value);
            iop_pkg::OFS_OPEN_DRAIN:  rdata_nxt = 16'(open_drain_select_r);
            iop_pkg::OFS_SEL_FIRST:   rdata_nxt = 16'(first_converter_pin_select_r);
            iop_pkg::OFS_SEL_SECOND:  rdata_nxt = 16'(second_converter_pin_select_r);
            iop_pkg::OFS_CHG_EN_LOW:  rdata_nxt = change_enable_low_reg_r;
            iop_pkg::OFS_CHG_EN_HIGH: rdata_nxt = change_enable_high_reg_r;
            iop_pkg::OFS_PU_EN_LOW:   rdata_nxt = pullup_enable_low_reg_r;
            iop_pkg::OFS_PU_EN_HIGH:  rdata_nxt = pullup_enable_high_reg_r;
            iop_pkg::OFS_IRQ_STATUS:  rdata_nxt = {15'h0000, irq_status_r};
            iop_pkg::OFS_IRQ_MASK:    rdata_nxt = {15'h0000, irq_mask_r};
            default:                  rdata_nxt = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         rdata_r <= 16'h0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign REG_RDATA_O = rdata_r;

endmodule : iop_port

// *** verif/iop_pins.sv ***
// far side: keys to ground, outside sources and the enabled weak pull-ups
`timescale 1ns/1ps
module iop_pins (
   input  wire logic [15:0] pin_o_i,
   input  wire logic [15:0] pin_oe_n_i,
   input  wire logic [23:0] pullup_en_i,
   input  wire logic [15:0] ext_level_i,
   input  wire logic [23:0] ext_change_i,
   input  wire logic [23:0] pressed_i,
   output logic      [15:0] pin_o,
   output logic      [23:0] change_pin_o
);
   // released pins show the outside source, never the last driven value
   assign pin_o = (pin_o_i & ~pin_oe_n_i) | (ext_level_i & pin_oe_n_i);
   // key lines carry board pull-downs, so an idle line needs the weak pull-up
   assign change_pin_o = ~pressed_i & (pullup_en_i | ext_change_i);
endmodule : iop_pins

// *** verif/iop_port_monitor.sv ***
// concurrent checks on the ports of the pin configuration block
`timescale 1ns/1ps
module iop_port_monitor #(
   parameter int PINS    = 16,
   parameter int CHANGES = 24
) (
   input wire logic                 CLOCK_I,
   input wire logic                 RESET_I,
   input wire logic [3:0]           REG_ADDR_I,
   input wire logic                 REG_WRITE_I,
   input wire logic                 REG_READ_I,
   input wire logic [15:0]          REG_RDATA_O,
   input wire logic [PINS-1:0]      PIN_I,
   input wire logic [PINS-1:0]      PIN_O,
   input wire logic [PINS-1:0]      PIN_OE_N_O,
   input wire logic [CHANGES-1:0]   PULLUP_EN_O,
   input wire logic                 SLEEP_I,
   input wire logic [PINS-1:0]      CONVERTER_SAMPLE_EN_O,
   input wire logic [PINS-1:0]      CONVERTER_LEVEL_O,
   input wire logic [PINS-1:0]      CONVERTER_GROUND_O,
   input wire logic                 IRQ_O
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RESET_I);
   //////////////////////////////////////////////////////////////////////////////
   mode_split_a: assert property (CONVERTER_SAMPLE_EN_O == ~CONVERTER_GROUND_O)
      else $error("analog and grounded flags overlap");
   reset_analog_a: assert property ($past(RESET_I) |-> CONVERTER_SAMPLE_EN_O == '1)
      else $error("pins not analog after reset");
   reset_quiet_a: assert property ($past(RESET_I) |-> PULLUP_EN_O == '0 && PIN_OE_N_O == '1)
      else $error("pull-ups or drivers on after reset");
   drive_level_a: assert property (((PIN_O ^ CONVERTER_LEVEL_O) & ~PIN_OE_N_O) == '0)
      else $error("converter level differs from driven level");
   port_zero_a: assert property ($past(REG_READ_I) && $past(REG_ADDR_I) == iop_pkg::OFS_PORT
      |-> (REG_RDATA_O & $past(CONVERTER_SAMPLE_EN_O)) == '0) else $error("analog bit read as one");
   pin_sync_a: assert property (REG_READ_I && REG_ADDR_I == iop_pkg::OFS_PORT
      && PIN_I == $past(PIN_I) && PIN_I == $past(PIN_I, 2) && PIN_I == $past(PIN_I, 3)
      |=> REG_RDATA_O == ($past(PIN_I) & ~$past(CONVERTER_SAMPLE_EN_O)))
      else $error("port read differs from settled pins");
   irq_hold_a: assert property (IRQ_O && !SLEEP_I && !(REG_READ_I
      && REG_ADDR_I == iop_pkg::OFS_IRQ_STATUS) && !(REG_WRITE_I
      && REG_ADDR_I == iop_pkg::OFS_IRQ_MASK) |=> IRQ_O) else $error("interrupt dropped");
   irq_status_a: assert property (REG_READ_I && REG_ADDR_I == iop_pkg::OFS_IRQ_STATUS
      && IRQ_O && !SLEEP_I |=> REG_RDATA_O[0]) else $error("interrupt without status bit");
endmodule : iop_port_monitor

// *** verif/tb_iop_port.sv ***
// self-checking bench for the pin configuration block
`timescale 1ns/1ps
module tb_iop_port;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic        wr_s = 1'b0;
   logic        rd_s = 1'b0;
   logic        sleep = 1'b0;
   logic [23:0] prs = 24'h000000;
   logic [15:0] rdata, pin_i, pin_o, oe_n, smp, lvl, gnd;
   logic [23:0] chg, pu;
   logic        irq;
   int          err_count = 0;
   int          num_checks = 0;
   always #10 clk = ~clk;
   iop_port uut (.CLOCK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
      .REG_WRITE_I(wr_s), .REG_READ_I(rd_s), .REG_RDATA_O(rdata), .PIN_I(pin_i),
      .PIN_O(pin_o), .PIN_OE_N_O(oe_n), .CHANGE_PIN_I(chg), .PULLUP_EN_O(pu),
      .SLEEP_I(sleep), .CONVERTER_SAMPLE_EN_O(smp), .CONVERTER_LEVEL_O(lvl),
      .CONVERTER_GROUND_O(gnd), .IRQ_O(irq));
   iop_pins pins (.pin_o_i(pin_o), .pin_oe_n_i(oe_n), .pullup_en_i(pu),
      .ext_level_i(16'ha5a5), .ext_change_i(24'h000000), .pressed_i(prs),
      .pin_o(pin_i), .change_pin_o(chg));
   //////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic print_verdict();
      if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr
   // the strobe gap before a read covers the settle cycle software must leave
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk($sformatf("reg %h", a), {8'h00, rdata}, {8'h00, e});
   endtask : rd
   task automatic wait_irq(input logic e);
      int n;
      n = 0;
      while (irq !== e && n < 20) begin
         @(posedge clk);
         #1 n++;
      end
      chk("irq", {23'h0, irq}, {23'h0, e});
      if (irq !== e) print_verdict();
   endtask : wait_irq
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 13; a++) rd(4'(a), (a == 1) ? 16'hffff : 16'h0000);
      wr(iop_pkg::OFS_LATCH, 16'h00ff);
      wr(iop_pkg::OFS_DIRECTION, 16'hff00);
      wr(iop_pkg::OFS_OPEN_DRAIN, 16'h000f);
      #1 chk("oe_n", {8'h00, oe_n}, 24'h00ff0f);
      chk("pin_o", {8'h00, pin_o}, 24'h0000f0);
      chk("level", {8'h00, lvl}, 24'h0000ff);
      wr(iop_pkg::OFS_PORT, 16'h0000);
      #1 chk("oe_n", {8'h00, oe_n}, 24'h00ff00);
      wr(iop_pkg::OFS_SEL_FIRST, 16'h0ff0);
      #1 chk("sample", {8'h00, smp}, 24'h00ffff);
      wr(iop_pkg::OFS_SEL_SECOND, 16'hfff0);
      #1 chk("sample", {8'h00, smp}, 24'h00f00f);
      chk("ground", {8'h00, gnd}, 24'h000ff0);
      // inputs 11:8 show the source, outputs 7:4 their own low level
      rd(iop_pkg::OFS_PORT, 16'h0500);
      wr(iop_pkg::OFS_PU_EN_LOW, 16'h0001);
      wr(iop_pkg::OFS_PU_EN_HIGH, 16'hffff);
      #1 chk("pullup", pu, 24'hff0001);
      rd(iop_pkg::OFS_PU_EN_HIGH, 16'h00ff);
      rd(iop_pkg::OFS_IRQ_STATUS, 16'h0000);
      wr(iop_pkg::OFS_IRQ_MASK, 16'h0001);
      for (int k = 0; k < 2; k++) begin
         wr(k ? iop_pkg::OFS_CHG_EN_HIGH : iop_pkg::OFS_CHG_EN_LOW, k ? 16'h0080 : 16'h0001);
         prs[k ? 23 : 0] <= 1'b1;
         wait_irq(1'b1);
         rd(iop_pkg::OFS_IRQ_STATUS, 16'h0001);
         wait_irq(1'b0);
      end
      wr(iop_pkg::OFS_IRQ_MASK, 16'h0000);
      prs[23] <= 1'b0;
      repeat (6) @(posedge clk);
      #1 chk("irq", {23'h0, irq}, 24'h000000);
      rd(iop_pkg::OFS_IRQ_STATUS, 16'h0001);
      wr(iop_pkg::OFS_IRQ_MASK, 16'h0001);
      sleep <= 1'b1;
      prs[0] <= 1'b0;
      wait_irq(1'b1);
      @(posedge clk);
      sleep <= 1'b0;
      rd(iop_pkg::OFS_IRQ_STATUS, 16'h0001);
      wr(iop_pkg::OFS_PU_EN_LOW, 16'h0000);
      #1 chk("pullup", pu, 24'hff0000);
      print_verdict();
   end
endmodule : tb_iop_port
bind iop_port iop_port_monitor #(.PINS(PINS), .CHANGES(CHANGES)) mon (.*);
